// file: inc/dcr_pkg.sv
/*
 * Package for the converter control block: register indices, field positions,
 * reset values, buffer modes and the packed control structs.
 * Assumes an APB master with 32-bit data; each register index maps to byte address index * 4.
 */
`default_nettype none

package dcr_pkg;

    localparam int unsigned APB_AW = 12;

    // printed offsets are indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] IDX_CTRL0  = 8'h21;
    localparam logic [7:0] IDX_CTRL1  = 8'h22;
    localparam logic [7:0] IDX_CTRL2  = 8'h23;

    localparam int unsigned C0_EN   = 7;
    localparam int unsigned C0_RFS  = 6;
    localparam int unsigned C0_TRG  = 5;
    localparam int unsigned C0_SWT  = 4;
    localparam int unsigned C0_LP   = 3;
    localparam int unsigned C0_TIE  = 1;
    localparam int unsigned C0_BIE  = 0;

    localparam int unsigned C1_DMA  = 7;
    localparam int unsigned C1_MDH  = 2;
    localparam int unsigned C1_MDL  = 1;
    localparam int unsigned C1_BFEN = 0;

    localparam int unsigned C2_RP   = 4;
    localparam int unsigned C2_UP   = 0;

    // status bits share the layout of the enable bits in control zero
    localparam int unsigned SR_TOP  = 1;
    localparam int unsigned SR_BOT  = 0;

    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [1:0] STATUS_RESET = 2'h2;

    typedef enum logic [1:0] {
        DCR_MODE_NORMAL = 2'h0,
        DCR_MODE_RSVD   = 2'h1,
        DCR_MODE_SCAN   = 2'h2,
        DCR_MODE_FIFO   = 2'h3
    } dcr_mode_t;

    typedef struct packed {
        logic       system_enable;
        logic       reference_select;
        logic       trigger_source_select;
        logic       low_power_select;
        logic       top_flag_irq_enable;
        logic       bottom_flag_irq_enable;
    } dcr_ctrl0_t;

    typedef struct packed {
        logic       dma_request_enable;
        dcr_mode_t  buffer_work_mode;
        logic       buffer_pointer_enable;
    } dcr_ctrl1_t;

    localparam dcr_ctrl0_t CTRL0_RESET = '0;
    localparam dcr_ctrl1_t CTRL1_RESET = '{1'b0, DCR_MODE_NORMAL, 1'b0};

endpackage

`default_nettype wire

// file: src/dcr_sync.sv
/*
 * Two-flop level synchroniser for a pin from outside the clock domain.
 * Assumes the pin is a level held for at least two clock periods.
 */
`default_nettype none

module dcr_sync (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

`default_nettype wire

// file: src/dcr_top.sv
/*
 * Converter control registers with APB slave, buffer read-pointer stepping,
 * pointer flags, interrupt and DMA request routing.
 * Assumes the hardware trigger is an asynchronous pin and dma_done_i comes
 * from a DMA engine on clk_i.
 */
`default_nettype none

module dcr_top #(
    parameter int unsigned PTR_W = 1
) (
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [dcr_pkg::APB_AW-1:0]  paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    input  wire logic [3:0]                  pstrb_i,
    output logic [31:0]                      prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    input  wire logic                        hw_trigger_i,
    input  wire logic                        dma_done_i,
    output logic                             dac_enable_o,
    output logic                             reference_select_o,
    output logic                             low_power_select_o,
    output logic [PTR_W-1:0]                 word_select_o,
    output logic                             irq_o,
    output logic                             dma_req_o
);

    dcr_pkg::dcr_ctrl0_t ctrl0_reg;
    dcr_pkg::dcr_ctrl1_t ctrl1_reg;
    logic [PTR_W-1:0]    read_ptr_reg;
    logic [PTR_W-1:0]    read_ptr_next;
    logic [PTR_W-1:0]    upper_reg;
    logic [1:0]          status_reg;
    logic [1:0]          status_set;
    logic                sw_trig_reg;
    logic                hw_sync;
    logic                hw_prev_reg;
    logic                trigger;
    logic                advance;
    logic                ptr_load;
    logic [31:0]         prdata_reg;
    logic                err_reg;
    logic [PTR_W-1:0]    word_sel_reg;
    logic                write_go;
    logic                setup;
    logic [7:0]          wbyte;
    logic [7:0]          idx;
    logic [1:0]          flags_pending;

    // register index from byte address, aligned word only
    function automatic logic [7:0] addr_index(input logic [dcr_pkg::APB_AW-1:0] a);
        addr_index = a[9:2];
    endfunction

    function automatic logic addr_aligned(input logic [dcr_pkg::APB_AW-1:0] a);
        addr_aligned = (a[1:0] == 2'h0) && (a[dcr_pkg::APB_AW-1:10] == '0);
    endfunction

    function automatic logic addr_mapped(input logic [dcr_pkg::APB_AW-1:0] a);
        logic [7:0] i;
        i = addr_index(a);
        addr_mapped = addr_aligned(a) && (i == dcr_pkg::IDX_STATUS || i == dcr_pkg::IDX_CTRL0
                      || i == dcr_pkg::IDX_CTRL1 || i == dcr_pkg::IDX_CTRL2);
    endfunction

    dcr_sync u_trig_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (hw_trigger_i),
        .sync_o    (hw_sync)
    );

    assign setup    = psel_i && !penable_i;
    assign idx      = addr_index(paddr_i);
    assign wbyte    = pwdata_i[7:0];
    // zero-wait access phase; read data was captured in the setup cycle
    assign pready_o  = psel_i && penable_i;
    assign pslverr_o = pready_o && err_reg;
    assign prdata_o  = prdata_reg;
    assign write_go = pready_o && pwrite_i && !err_reg && pstrb_i[0];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else if (setup) begin
            err_reg    <= !addr_mapped(paddr_i);
            prdata_reg <= 32'h0000_0000;
            if (!pwrite_i && addr_mapped(paddr_i)) begin
                if (idx == dcr_pkg::IDX_STATUS) begin
                    prdata_reg[dcr_pkg::SR_TOP] <= status_reg[dcr_pkg::SR_TOP];
                    prdata_reg[dcr_pkg::SR_BOT] <= status_reg[dcr_pkg::SR_BOT];
                end else if (idx == dcr_pkg::IDX_CTRL0) begin
                    // strobe bit always reads zero
                    prdata_reg[dcr_pkg::C0_EN]  <= ctrl0_reg.system_enable;
                    prdata_reg[dcr_pkg::C0_RFS] <= ctrl0_reg.reference_select;
                    prdata_reg[dcr_pkg::C0_TRG] <= ctrl0_reg.trigger_source_select;
                    prdata_reg[dcr_pkg::C0_LP]  <= ctrl0_reg.low_power_select;
                    prdata_reg[dcr_pkg::C0_TIE] <= ctrl0_reg.top_flag_irq_enable;
                    prdata_reg[dcr_pkg::C0_BIE] <= ctrl0_reg.bottom_flag_irq_enable;
                end else if (idx == dcr_pkg::IDX_CTRL1) begin
                    prdata_reg[dcr_pkg::C1_DMA]                  <= ctrl1_reg.dma_request_enable;
                    prdata_reg[dcr_pkg::C1_MDH:dcr_pkg::C1_MDL]  <= ctrl1_reg.buffer_work_mode;
                    prdata_reg[dcr_pkg::C1_BFEN]                 <= ctrl1_reg.buffer_pointer_enable;
                end else begin
                    prdata_reg[dcr_pkg::C2_RP +: PTR_W] <= read_ptr_reg;
                    prdata_reg[dcr_pkg::C2_UP +: PTR_W] <= upper_reg;
                end
            end
        end
    end

    // control zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl0_reg <= dcr_pkg::CTRL0_RESET;
        end else if (write_go && idx == dcr_pkg::IDX_CTRL0) begin
            ctrl0_reg.system_enable          <= wbyte[dcr_pkg::C0_EN];
            ctrl0_reg.reference_select       <= wbyte[dcr_pkg::C0_RFS];
            ctrl0_reg.trigger_source_select  <= wbyte[dcr_pkg::C0_TRG];
            ctrl0_reg.low_power_select       <= wbyte[dcr_pkg::C0_LP];
            ctrl0_reg.top_flag_irq_enable    <= wbyte[dcr_pkg::C0_TIE];
            ctrl0_reg.bottom_flag_irq_enable <= wbyte[dcr_pkg::C0_BIE];
        end
    end

    // strobe is judged one cycle later, against the values written alongside it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sw_trig_reg <= 1'b0;
        end else begin
            sw_trig_reg <= write_go && idx == dcr_pkg::IDX_CTRL0 && wbyte[dcr_pkg::C0_SWT];
        end
    end

    // control one; reserved mode code is kept and behaves as normal
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl1_reg <= dcr_pkg::CTRL1_RESET;
        end else if (write_go && idx == dcr_pkg::IDX_CTRL1) begin
            ctrl1_reg.dma_request_enable    <= wbyte[dcr_pkg::C1_DMA];
            ctrl1_reg.buffer_work_mode      <= dcr_pkg::dcr_mode_t'(wbyte[dcr_pkg::C1_MDH:dcr_pkg::C1_MDL]);
            ctrl1_reg.buffer_pointer_enable <= wbyte[dcr_pkg::C1_BFEN];
        end
    end

    // hardware trigger acts on its rising edge after synchronisation
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hw_prev_reg <= 1'b0;
        end else begin
            hw_prev_reg <= hw_sync;
        end
    end

    always_comb begin
        if (ctrl0_reg.trigger_source_select) begin
            trigger = sw_trig_reg;
        end else begin
            trigger = hw_sync && !hw_prev_reg;
        end
    end

    // one-time scan parks at the limit instead of wrapping
    assign advance = trigger && ctrl0_reg.system_enable && ctrl1_reg.buffer_pointer_enable
                     && !(ctrl1_reg.buffer_work_mode == dcr_pkg::DCR_MODE_SCAN
                          && read_ptr_reg == upper_reg);
    assign ptr_load = write_go && idx == dcr_pkg::IDX_CTRL2;

    always_comb begin
        if (ptr_load) begin
            read_ptr_next = pwdata_i[dcr_pkg::C2_RP +: PTR_W];
        end else if (advance && read_ptr_reg == upper_reg) begin
            read_ptr_next = '0;
        end else if (advance) begin
            read_ptr_next = read_ptr_reg + PTR_W'(1);
        end else begin
            read_ptr_next = read_ptr_reg;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_ptr_reg <= '0;
            upper_reg    <= '1;
        end else begin
            read_ptr_reg <= read_ptr_next;
            if (ptr_load) begin
                upper_reg <= pwdata_i[dcr_pkg::C2_UP +: PTR_W];
            end
        end
    end

    // flags set only when the pointer moves or is loaded
    always_comb begin
        status_set = 2'h0;
        if (advance || ptr_load) begin
            status_set[dcr_pkg::SR_TOP] = (read_ptr_next == '0);
            status_set[dcr_pkg::SR_BOT] = (read_ptr_next == upper_reg);
        end
    end

    assign flags_pending = status_reg & {ctrl0_reg.top_flag_irq_enable, ctrl0_reg.bottom_flag_irq_enable};

    // clear by writing 0 or by DMA completion; a same-cycle set wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_reg <= dcr_pkg::STATUS_RESET;
        end else begin
            if (write_go && idx == dcr_pkg::IDX_STATUS) begin
                status_reg <= (status_reg & wbyte[1:0]) | status_set;
            end else if (dma_done_i && ctrl1_reg.dma_request_enable) begin
                status_reg <= (status_reg & ~flags_pending) | status_set;
            end else begin
                status_reg <= status_reg | status_set;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            word_sel_reg <= '0;
        end else if (ctrl1_reg.buffer_pointer_enable) begin
            word_sel_reg <= read_ptr_next;
        end else begin
            word_sel_reg <= '0;
        end
    end

    assign word_select_o      = word_sel_reg;
    assign dac_enable_o       = ctrl0_reg.system_enable;
    assign reference_select_o = ctrl0_reg.reference_select;
    assign low_power_select_o = ctrl0_reg.low_power_select;
    assign irq_o     = !ctrl1_reg.dma_request_enable && (|flags_pending);
    assign dma_req_o = ctrl1_reg.dma_request_enable && (|flags_pending);

endmodule

`default_nettype wire

// file: tb/dcr_far_model.sv
/*
 * Far-side model: a DMA engine that answers a standing request after a short delay,
 * and a source of hardware trigger pin pulses.
 * Assumes the bench pulses go_i for one clock per trigger.
 */
`default_nettype none

module dcr_far_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic go_i,
    input  wire logic dma_req_i,
    output logic      hw_trigger_o,
    output logic      dma_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly_reg;
    logic [2:0] pin_reg;

    // one done pulse every fifth clock while the request stays high; the counter rests one clock after each pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dly_reg    <= 3'h0;
            dma_done_o <= 1'b0;
        end else begin
            dma_done_o <= dma_req_i && dly_reg == 3'h3;
            dly_reg    <= (dma_req_i && !dma_done_o && dly_reg != 3'h3) ? dly_reg + 3'h1 : 3'h0;
        end
    end

    // pin held high four clocks so the two-flop sampler always sees it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) pin_reg <= 3'h0;
        else if (go_i) pin_reg <= 3'h4;
        else if (pin_reg != 3'h0) pin_reg <= pin_reg - 3'h1;
    end
    assign hw_trigger_o = pin_reg != 3'h0;
endmodule

`default_nettype wire

// file: tb/dcr_top_asserts.sv
/*
 * Checker for the converter control ports: shadows the control writes and ties
 * outputs, read-back and pointer stepping to them.
 * Assumes the APB slave answers with zero wait states.
 */
`default_nettype none

module dcr_top_asserts #(
    parameter int unsigned PTR_W = 1
) (
    input wire logic                       clk_i,
    input wire logic                       reset_n_i,
    input wire logic                       psel_i,
    input wire logic                       penable_i,
    input wire logic                       pwrite_i,
    input wire logic [dcr_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0]                pwdata_i,
    input wire logic [3:0]                 pstrb_i,
    input wire logic [31:0]                prdata_o,
    input wire logic                       pready_o,
    input wire logic                       pslverr_o,
    input wire logic                       hw_trigger_i,
    input wire logic                       dma_done_i,
    input wire logic                       dac_enable_o,
    input wire logic                       reference_select_o,
    input wire logic                       low_power_select_o,
    input wire logic [PTR_W-1:0]           word_select_o,
    input wire logic                       irq_o,
    input wire logic                       dma_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] c0_reg;
    logic [7:0] c1_reg;
    wire logic  wr = psel_i & penable_i & pwrite_i & pstrb_i[0];
    wire logic  rd = psel_i & penable_i & !pwrite_i;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            c0_reg <= 8'h00;
            c1_reg <= 8'h00;
        end else begin
            if (wr && paddr_i == 12'h084) c0_reg <= pwdata_i[7:0];
            if (wr && paddr_i == 12'h088) c1_reg <= pwdata_i[7:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_strobe;
        wr && paddr_i == 12'h084 && pwdata_i[7] && pwdata_i[5] && pwdata_i[4];
    endsequence
    // scan mode may sit at the limit, so only wrapping modes must move
    sequence s_stepping;
        c1_reg[0] && c1_reg[2:1] != 2'h2;
    endsequence

    AST_CTRL_OUT: assert property (
        {dac_enable_o, reference_select_o, low_power_select_o} == {c0_reg[7], c0_reg[6], c0_reg[3]})
        else $error("control output differs from written value");
    AST_IRQ_NOT_DMA: assert property (irq_o |-> !c1_reg[7])
        else $error("interrupt raised while DMA routing on");
    AST_IRQ_NEEDS_EN: assert property (irq_o |-> c0_reg[1:0] != 2'h0)
        else $error("interrupt raised with no flag enable");
    AST_DMA_ONLY: assert property (dma_req_o |-> c1_reg[7] && c0_reg[1:0] != 2'h0)
        else $error("dma request without routing or enable");
    AST_SWT_READ0: assert property (rd && paddr_i == 12'h084 |-> prdata_o[4] == 1'b0 && prdata_o[2] == 1'b0)
        else $error("strobe or reserved bit read as one");
    AST_RSVD_C1: assert property (rd && paddr_i == 12'h088 |-> prdata_o[6:3] == 4'h0)
        else $error("reserved bits of control one not zero");
    AST_WORDSEL_ZERO: assert property (!c1_reg[0] && !$past(c1_reg[0]) |-> word_select_o == '0)
        else $error("word select not zero with pointer off");
    AST_SWT_STEP: assert property (s_strobe ##0 s_stepping |-> ##[1:4] $changed(word_select_o))
        else $error("software strobe did not step the pointer");
    AST_NO_STEP_OFF: assert property (wr && paddr_i == 12'h084 && !pwdata_i[7] |=> $stable(word_select_o) [*4])
        else $error("pointer moved with converter disabled");
endmodule

bind dcr_top dcr_top_asserts #(.PTR_W(PTR_W)) i_asserts (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .hw_trigger_i(hw_trigger_i), .dma_done_i(dma_done_i), .dac_enable_o(dac_enable_o),
    .reference_select_o(reference_select_o), .low_power_select_o(low_power_select_o),
    .word_select_o(word_select_o), .irq_o(irq_o), .dma_req_o(dma_req_o));

`default_nettype wire

// file: tb/dac_control_registers_tb.sv
/*
 * Bench for dcr_top: APB master tasks, an integer model of controls, flags and pointer,
 * random and table scenarios compared after every step.
 * Assumes dcr_far_model answers DMA requests and makes trigger pulses.
 */
`default_nettype none

module dac_control_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic                       pwrite_i = 1'b0, go = 1'b0;
    logic [dcr_pkg::APB_AW-1:0] paddr_i = '0;
    logic [31:0]                pwdata_i = '0;
    logic [3:0]                 pstrb_i = 4'hF;
    wire logic [31:0]           prdata_o;
    wire logic                  pready_o, pslverr_o, hw_trigger_i, dma_done_i, irq_o, dma_req_o;
    wire logic                  dac_enable_o, reference_select_o, low_power_select_o;
    wire logic [0:0]            word_select_o;
    int                         miscompares = 0, check_count = 0, st = 2, c0 = 0, c1 = 0, ptr = 0, seed = 81;
    localparam int              UP = 1;
    localparam logic [31:0]     TBL [13] = '{32'h0001B300, 32'hFF01B300, 32'hFF013300, 32'hFF019300,
        32'hFF05B300, 32'hFF05B300, 32'h01018301, 32'hFF00B300, 32'h0003B000, 32'hFF07B100,
        32'hFF81B300, 32'hFF818201, 32'h00000000};

    dcr_top #(.PTR_W(1)) i_dut (
        .clk_i              (clk_i),
        .reset_n_i          (reset_n_i),
        .psel_i             (psel_i),
        .penable_i          (penable_i),
        .pwrite_i           (pwrite_i),
        .paddr_i            (paddr_i),
        .pwdata_i           (pwdata_i),
        .pstrb_i            (pstrb_i),
        .prdata_o           (prdata_o),
        .pready_o           (pready_o),
        .pslverr_o          (pslverr_o),
        .hw_trigger_i       (hw_trigger_i),
        .dma_done_i         (dma_done_i),
        .dac_enable_o       (dac_enable_o),
        .reference_select_o (reference_select_o),
        .low_power_select_o (low_power_select_o),
        .word_select_o      (word_select_o),
        .irq_o              (irq_o),
        .dma_req_o          (dma_req_o)
    );
    dcr_far_model i_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .dma_req_i(dma_req_o),
        .hw_trigger_o(hw_trigger_i), .dma_done_o(dma_done_i));

    initial forever #5 clk_i = ~clk_i;

    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            miscompares++;
            $display("BAD reg t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic chk_pin(input logic [5:0] g, input logic [5:0] x);
        check_count++;
        if (g !== x) begin
            miscompares++;
            $display("BAD pin t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_reg(r, x);
        chk_reg({31'h0, e}, {31'h0, xe});
    endtask

    // dma engine clears the enabled flags while we wait
    task automatic settle();
        repeat (16) @(posedge clk_i);
        if (c1[7]) st = st & ~(c0 & 3);
    endtask

    task automatic apply(input logic [7:0] sv, input logic [7:0] c1w, input logic [7:0] c0w, input logic hw);
        logic q;
        wr(12'h080, sv);
        st = st & (sv | 8'hFC);
        wr(12'h088, c1w);
        c1 = c1w & 8'h87;
        settle();
        wr(12'h084, c0w);
        c0 = c0w & 8'hEB;
        if (hw) begin
            @(posedge clk_i);
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
        end
        if (c0w[7] && c1w[0] && (hw ? !c0w[5] : c0w[5] && c0w[4])) begin
            // scan parked at the limit: pointer holds, so no flag is set
            if (c1w[2:1] != 2'h2 || ptr != UP) begin
                ptr = (ptr == UP) ? 0 : ptr + 1;
                st = st | (ptr == UP) | ((ptr == 0) << 1);
            end
        end
        settle();
        q = (st & c0 & 3) != 0;
        rd(12'h080, st, 1'b0);
        rd(12'h084, c0, 1'b0);
        rd(12'h088, c1, 1'b0);
        rd(12'h08C, (ptr << 4) | UP, 1'b0);
        chk_pin({dac_enable_o, reference_select_o, low_power_select_o, word_select_o, irq_o, dma_req_o},
            {c0[7], c0[6], c0[3], c1[0] && ptr[0], q && !c1[7], q && c1[7]});
        $display("test done t=%0t", $time);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #50000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(12'h080, 32'h2, 1'b0);
        rd(12'h084, 32'h0, 1'b0);
        rd(12'h088, 32'h0, 1'b0);
        rd(12'h08C, 32'h1, 1'b0);
        rd(12'h090, 32'h0, 1'b1);
        rd(12'h085, 32'h0, 1'b1);
        pstrb_i <= 4'hE;
        wr(12'h088, 8'h81);
        pstrb_i <= 4'hF;
        rd(12'h088, 32'h0, 1'b0);
        $display("test done t=%0t", $time);
        repeat (6) apply(8'(xs()), 8'(xs()) & 8'hFE, 8'(xs()), 1'b0);
        foreach (TBL[i]) apply(TBL[i][31:24], TBL[i][23:16], TBL[i][15:8], TBL[i][0]);
        // pointer load: flags follow the loaded pointer, limit stays one
        wr(12'h08C, 8'h11);
        ptr = 1;
        st = st | 1;
        rd(12'h08C, 32'h11, 1'b0);
        rd(12'h080, st, 1'b0);
        wr(12'h08C, 8'h01);
        ptr = 0;
        st = st | 2;
        rd(12'h08C, 32'h01, 1'b0);
        rd(12'h080, st, 1'b0);
        $display("test done t=%0t", $time);
        report_and_stop();
    end
endmodule

`default_nettype wire
